// >>> verilog/gate_driver_config_register_bank.sv
// Purpose: serial-port register bank and primary-side configuration
// Assumes: frames of 16 bits, msb first, sampled on sclk rise, shifted on fall
// Notes: device state, ADC results and fault flags come from core logic
//
// Summary of operation
// - ADC results for inputs five, two, four, six read at 0xD..0x10, no CRC.
// - die temperature reads at 0x11, divided gate output voltage at 0x12.
// - CRC value register 0x13 writable only in Configuration 2.
// - loopback test register 0x14 writable in Configuration 2 and Active.
// - chip address register 0x15 writable only in Configuration 1.
// - five fault status registers 0x16..0x1A are read only.
// - diagnostic registers 0x1B, 0x1C writable in Configuration 2 and Active.
// - converter 0x1D and pin 0x1E settings writable only in Configuration 2.
// - bit 15 disables undervoltage lockout, bit 14 picks its threshold.
// - bit 8 disables overvoltage lockout, bit 13 picks its threshold.
// - bits 12-11 deglitch both PWM inputs: bypass, 70, 140, 210 ns.
// - bit 10 resets to one; zero enables the temperature warning.
// - bits 5-0 add code times 70 ns plus 105 ns dead time; zero adds none.
// - reserved bits 9 and 7 store values, reset to zero, do nothing.
// - sixteen-bit registers written by high and low byte commands.
// - a read command to the own address returns the whole register in the next frame.
`timescale 1ns/1ns
`default_nettype none
module gate_driver_config_register_bank (
  input wire logic clk, // 20 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // serial select pin, active low
  input wire logic mosi, // serial data in pin
  input wire gate_cfg_pkg::dev_state_e dev_state, // device state from core
  input wire gate_cfg_pkg::adc_results_s adc_in, // converter results
  input wire gate_cfg_pkg::fault_flags_s faults_in, // fault and pin flags
  input wire logic fault_event, // fault routed to alarm pin
  input wire logic primary_temp_warn, // primary overtemperature seen
  input wire logic pwm_input_positive, // PWM pin, positive
  input wire logic pwm_input_negative, // PWM pin, negative
  output logic fault_alarm_out_n, // alarm pin, active low
  output logic warning_out_n, // shared pin value
  output logic warning_out_oe, // shared pin driven
  output logic [1:0] pwm_filtered, // deglitched positive, negative
  output logic [6:0] dead_time_cycles, // added dead time in clocks
  output logic [15:0] primary_side_config, // primary-side settings
  output logic [15:0] diag_command_one, // diagnostic word one
  output logic [15:0] diag_command_two, // diagnostic word two
  output logic [15:0] converter_settings, // converter settings word
  output logic [15:0] serial_out_pin_settings // pin settings word
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  // {valid, slot} of a writable register
  function automatic logic [3:0] slot_of(input logic [4:0] a);
    case (a)
      gate_cfg_pkg::OFF_PRIMARY: slot_of = 4'h8;
      gate_cfg_pkg::OFF_CRC: slot_of = 4'h9;
      gate_cfg_pkg::OFF_LOOPBACK: slot_of = 4'hA;
      gate_cfg_pkg::OFF_CHIP_ADDR: slot_of = 4'hB;
      gate_cfg_pkg::OFF_DIAG_ONE: slot_of = 4'hC;
      gate_cfg_pkg::OFF_DIAG_TWO: slot_of = 4'hD;
      gate_cfg_pkg::OFF_CONV: slot_of = 4'hE;
      gate_cfg_pkg::OFF_DOUT: slot_of = 4'hF;
      default: slot_of = 4'h0;
    endcase
  endfunction

  function automatic logic may_write(input logic [3:0] s, input gate_cfg_pkg::dev_state_e st);
    case (s)
      4'hB: may_write = (st == gate_cfg_pkg::state_primary_side_config);
      4'hA, 4'hC, 4'hD: may_write = (st != gate_cfg_pkg::state_primary_side_config);
      4'h8, 4'h9, 4'hE, 4'hF: may_write = (st == gate_cfg_pkg::state_cfg2);
      default: may_write = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // sclk, cs_n, mosi, pwm positive, pwm negative
  logic [4:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 5'h02;
      s2_q <= 5'h02;
      s3_q <= 5'h02;
      lvl_q <= 5'h02;
    end else begin
      s1_q <= {pwm_input_negative, pwm_input_positive, mosi, cs_n, sclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  logic [4:0] lvl_prev_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lvl_prev_q <= 5'h02;
    else lvl_prev_q <= lvl_q;
  end
  logic sck_rise, sck_fall, sel_fall, sel_rise;
  assign sck_rise = lvl_q[0] && !lvl_prev_q[0] && !lvl_q[1];
  assign sck_fall = !lvl_q[0] && lvl_prev_q[0] && !lvl_q[1];
  assign sel_fall = !lvl_q[1] && lvl_prev_q[1];
  assign sel_rise = lvl_q[1] && !lvl_prev_q[1];

  // ************************************************************
  // serial engine and register storage
  // ************************************************************
  logic [15:0] regs_q [8];
  logic [15:0] regs_d [8];
  logic [15:0] in_q, in_d, out_q, out_d, rd_buf_q, rd_buf_d;
  logic [4:0] cnt_q, cnt_d, ra_q, ra_d;
  logic [15:0] rd_word;
  logic frame_done, for_me, wr_hit;
  logic [3:0] wslot;

  assign frame_done = sel_rise && (cnt_q == 5'(gate_cfg_pkg::FRAME_BITS));
  assign for_me = (in_q[15:12] == regs_q[3][3:0]) || (in_q[15:12] == gate_cfg_pkg::BROADCAST);
  assign wslot = slot_of(ra_q);
  assign wr_hit = frame_done && for_me && wslot[3] && may_write(wslot, dev_state)
    && (in_q[11:8] == gate_cfg_pkg::OP_WRH || in_q[11:8] == gate_cfg_pkg::OP_WRL);

  always_comb begin
    logic [3:0] rs;
    rs = slot_of(in_q[4:0]);
    case (in_q[4:0])
      gate_cfg_pkg::OFF_ADC_FIVE: rd_word = adc_in.in_five;
      gate_cfg_pkg::OFF_ADC_TWO: rd_word = adc_in.in_two;
      gate_cfg_pkg::OFF_ADC_FOUR: rd_word = adc_in.in_four;
      gate_cfg_pkg::OFF_ADC_SIX: rd_word = adc_in.in_six;
      gate_cfg_pkg::OFF_ADC_TEMP: rd_word = adc_in.die_temp;
      gate_cfg_pkg::OFF_ADC_GATE: rd_word = adc_in.gate_threshold;
      gate_cfg_pkg::OFF_FAULT_ONE: rd_word = faults_in.one;
      gate_cfg_pkg::OFF_FAULT_TWO: rd_word = faults_in.two;
      gate_cfg_pkg::OFF_FAULT_THREE: rd_word = faults_in.three;
      gate_cfg_pkg::OFF_FAULT_FOUR: rd_word = faults_in.four;
      gate_cfg_pkg::OFF_FAULT_FIVE: rd_word = faults_in.five;
      default: rd_word = rs[3] ? regs_q[rs[2:0]] : gate_cfg_pkg::WORD_RESET;
    endcase
  end

  always_comb begin
    in_d = in_q;
    out_d = out_q;
    cnt_d = cnt_q;
    ra_d = ra_q;
    rd_buf_d = rd_buf_q;
    for (int i = 0; i < 8; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (sel_fall) begin
      cnt_d = 5'h00;
      out_d = rd_buf_q;
    end else if (sck_rise) begin
      in_d = {in_q[14:0], lvl_q[2]};
      if (cnt_q != 5'h1F) cnt_d = cnt_q + 5'h01;
    end else if (sck_fall) begin
      out_d = {out_q[14:0], 1'b0};
    end
    if (frame_done && for_me) begin
      if (in_q[11:8] == gate_cfg_pkg::OP_WR_RA) ra_d = in_q[4:0];
      // broadcast reads would collide on the bus, so only own address answers
      if (in_q[11:8] == gate_cfg_pkg::OP_RD && in_q[15:12] != gate_cfg_pkg::BROADCAST) begin
        rd_buf_d = rd_word;
      end
    end
    if (wr_hit) begin
      if (in_q[11:8] == gate_cfg_pkg::OP_WRH) regs_d[wslot[2:0]][15:8] = in_q[7:0];
      else regs_d[wslot[2:0]][7:0] = in_q[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_q <= 16'h0000;
      out_q <= 16'h0000;
      cnt_q <= 5'h00;
      ra_q <= 5'h00;
      rd_buf_q <= 16'h0000;
      regs_q[0] <= gate_cfg_pkg::PRIMARY_RESET;
      for (int i = 1; i < 8; i++) begin
        regs_q[i] <= gate_cfg_pkg::WORD_RESET;
      end
    end else begin
      in_q <= in_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
      ra_q <= ra_d;
      rd_buf_q <= rd_buf_d;
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  assign primary_side_config = regs_q[0];
  assign diag_command_one = regs_q[4];
  assign diag_command_two = regs_q[5];
  assign converter_settings = regs_q[6];
  assign serial_out_pin_settings = regs_q[7];

  // ************************************************************
  // pin functions
  // ************************************************************
  logic pin_sel, warn_on;
  logic alarm_n_d, warn_n_d, warn_oe_d;
  logic [6:0] dead_d;
  assign pin_sel = regs_q[0][gate_cfg_pkg::BIT_PIN_SEL];
  assign warn_on = primary_temp_warn && !regs_q[0][gate_cfg_pkg::BIT_TWN_OFF];
  always_comb begin
    logic [5:0] code;
    code = regs_q[0][gate_cfg_pkg::DEAD_HI:0];
    alarm_n_d = !(fault_event || (pin_sel && warn_on));
    warn_n_d = pin_sel ? out_q[15] : !warn_on;
    warn_oe_d = !pin_sel || !lvl_q[1];
    // least time rounds up to whole clocks
    dead_d = (code == 6'h00) ? 7'h00 : 7'((32'(code) * gate_cfg_pkg::DEAD_STEP_NS
      + gate_cfg_pkg::DEAD_BASE_NS + gate_cfg_pkg::CLK_PERIOD_NS - 1) / gate_cfg_pkg::CLK_PERIOD_NS);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_alarm_out_n <= 1'b1;
      warning_out_n <= 1'b1;
      warning_out_oe <= 1'b1;
      dead_time_cycles <= 7'h00;
    end else begin
      fault_alarm_out_n <= alarm_n_d;
      warning_out_n <= warn_n_d;
      warning_out_oe <= warn_oe_d;
      dead_time_cycles <= dead_d;
    end
  end

  // ************************************************************
  // PWM input deglitch
  // ************************************************************
  logic [2:0] degl_cycles;
  always_comb begin
    logic [1:0] dc;
    dc = regs_q[0][gate_cfg_pkg::DEGL_HI:gate_cfg_pkg::DEGL_LO];
    degl_cycles = 3'((32'(dc) * gate_cfg_pkg::DEGL_STEP_NS + gate_cfg_pkg::CLK_PERIOD_NS - 1)
      / gate_cfg_pkg::CLK_PERIOD_NS);
  end
  for (genvar g = 0; g < 2; g++) begin : g_degl
    logic [2:0] n_q, n_d;
    logic f_q, f_d;
    always_comb begin
      n_d = 3'h0;
      f_d = f_q;
      if (degl_cycles == 3'h0) f_d = lvl_q[3 + g];
      else if (lvl_q[3 + g] != f_q) begin
        n_d = n_q + 3'h1;
        if (n_d >= degl_cycles) begin
          f_d = lvl_q[3 + g];
          n_d = 3'h0;
        end
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        n_q <= 3'h0;
        f_q <= 1'b0;
      end else begin
        n_q <= n_d;
        f_q <= f_d;
      end
    end
    assign pwm_filtered[g] = f_q;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] regs_prev [8];
  logic all_same;
  always_ff @(posedge clk) for (int i = 0; i < 8; i++) regs_prev[i] <= regs_q[i];
  always_comb begin
    all_same = 1'b1;
    for (int i = 0; i < 8; i++) if (regs_prev[i] != regs_q[i]) all_same = 1'b0;
  end
  sequence s_wr(logic [4:0] a);
    frame_done && for_me && ra_q == a && in_q[11:8] == gate_cfg_pkg::OP_WRL;
  endsequence
  property p_crc_gate;
    s_wr(gate_cfg_pkg::OFF_CRC) ##0 dev_state != gate_cfg_pkg::state_cfg2 |=> $stable(regs_q[1]);
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("crc reg written outside cfg2");
  property p_loop_active;
    s_wr(gate_cfg_pkg::OFF_LOOPBACK) ##0 dev_state == gate_cfg_pkg::state_active
      |=> regs_q[2][7:0] == $past(in_q[7:0]);
  endproperty
  a_loop_active: assert property (p_loop_active) else $error("loopback write lost");
  property p_addr_primary_side_config;
    s_wr(gate_cfg_pkg::OFF_CHIP_ADDR) ##0 dev_state == gate_cfg_pkg::state_primary_side_config
      |=> regs_q[3][7:0] == $past(in_q[7:0]);
  endproperty
  a_addr_primary_side_config: assert property (p_addr_primary_side_config) else $error("chip address write lost");
  property p_unmapped;
    frame_done && !wslot[3] |=> ##1 all_same;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state");
  property p_read_next;
    frame_done && for_me && in_q[11:8] == gate_cfg_pkg::OP_RD && in_q[15:12] != gate_cfg_pkg::BROADCAST
      |=> rd_buf_q == $past(rd_word);
  endproperty
  a_read_next: assert property (p_read_next) else $error("read data not captured");
  property p_dead_zero;
    regs_q[0][gate_cfg_pkg::DEAD_HI:0] == 6'h00 |=> dead_time_cycles == 7'h00;
  endproperty
  a_dead_zero: assert property (p_dead_zero) else $error("dead time added at code zero");
  property p_route;
    pin_sel && warn_on |=> !fault_alarm_out_n;
  endproperty
  a_route: assert property (p_route) else $error("warning not moved to alarm pin");
  property p_warn_pin;
    !pin_sel && warn_on |=> !warning_out_n && warning_out_oe;
  endproperty
  a_warn_pin: assert property (p_warn_pin) else $error("warning pin not low");
endmodule // gate_driver_config_register_bank
`default_nettype wire

// >>> include/gate_cfg_pkg.sv
// Purpose: shared constants and types for the gate driver register bank
// Assumes: 16-bit registers, 5-bit register offsets, 20 MHz clock
// Notes: offsets are register indices on the serial port
package gate_cfg_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [4:0] OFF_PRIMARY = 5'h00;
  localparam logic [4:0] OFF_ADC_FIVE = 5'h0D;
  localparam logic [4:0] OFF_ADC_TWO = 5'h0E;
  localparam logic [4:0] OFF_ADC_FOUR = 5'h0F;
  localparam logic [4:0] OFF_ADC_SIX = 5'h10;
  localparam logic [4:0] OFF_ADC_TEMP = 5'h11;
  localparam logic [4:0] OFF_ADC_GATE = 5'h12;
  localparam logic [4:0] OFF_CRC = 5'h13;
  localparam logic [4:0] OFF_LOOPBACK = 5'h14;
  localparam logic [4:0] OFF_CHIP_ADDR = 5'h15;
  localparam logic [4:0] OFF_FAULT_ONE = 5'h16;
  localparam logic [4:0] OFF_FAULT_TWO = 5'h17;
  localparam logic [4:0] OFF_FAULT_THREE = 5'h18;
  localparam logic [4:0] OFF_FAULT_FOUR = 5'h19;
  localparam logic [4:0] OFF_FAULT_FIVE = 5'h1A;
  localparam logic [4:0] OFF_DIAG_ONE = 5'h1B;
  localparam logic [4:0] OFF_DIAG_TWO = 5'h1C;
  localparam logic [4:0] OFF_CONV = 5'h1D;
  localparam logic [4:0] OFF_DOUT = 5'h1E;
  // ************************************************************
  // primary-side field positions and reset values
  // ************************************************************
  localparam int BIT_UV_OFF = 15;
  localparam int BIT_UV_SEL = 14;
  localparam int BIT_OV_SEL = 13;
  localparam int DEGL_HI = 12;
  localparam int DEGL_LO = 11;
  localparam int BIT_TWN_OFF = 10;
  localparam int BIT_OV_OFF = 8;
  localparam int BIT_PIN_SEL = 6;
  localparam int DEAD_HI = 5;
  localparam logic [15:0] PRIMARY_RESET = 16'h0C00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ************************************************************
  // serial frame layout and commands
  // ************************************************************
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] OP_WRH = 4'hA;
  localparam logic [3:0] OP_WRL = 4'hB;
  localparam logic [3:0] OP_WR_RA = 4'hC;
  localparam logic [3:0] OP_RD = 4'h9;
  localparam logic [3:0] BROADCAST = 4'hF;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEGL_STEP_NS = 70;
  localparam int DEAD_STEP_NS = 70;
  localparam int DEAD_BASE_NS = 105;
  typedef enum logic [1:0] {state_primary_side_config, state_cfg2, state_active} dev_state_e;
  typedef struct packed {
    logic [15:0] in_five;
    logic [15:0] in_two;
    logic [15:0] in_four;
    logic [15:0] in_six;
    logic [15:0] die_temp;
    logic [15:0] gate_threshold;
  } adc_results_s;
  typedef struct packed {
    logic [15:0] one;
    logic [15:0] two;
    logic [15:0] three;
    logic [15:0] four;
    logic [15:0] five;
  } fault_flags_s;
endpackage

// >>> testbench/spi_host_model.sv
// Purpose: behavioural serial host that sends whole frames to the register bank
// Assumes: frames of 16 bits msb first, device samples on sclk rise, shifts on fall
// Notes: paced by the system clock; sclk stands low outside frames
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input wire logic clk, // pacing clock
  input wire logic miso, // shared pin from the device
  output logic sclk, // serial clock, idle low
  output logic cs_n, // select, active low
  output logic mosi // serial data to the device
);
  localparam int HALF = 8; // clocks per sclk half; device answer trails each sclk fall by six clocks
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ************************************************************
  // one frame: the word goes out whole, the answer comes back whole
  // ************************************************************
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      mosi <= w[i];
      repeat (HALF - 1) @(posedge clk);
      @(negedge clk);
      r[i] = miso; // settled well before the rise
      @(posedge clk);
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~w[0]; // released line must not keep the last bit
    repeat (12) @(posedge clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> testbench/gate_driver_config_register_bank_bench.sv
// Purpose: self-checking bench for the register bank
// Assumes: chip address 0 after reset, data out readable once pin select is set
// Notes: table rows hold state, offset, written word and expected read back
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module gate_driver_config_register_bank_bench;
  localparam gate_cfg_pkg::dev_state_e S1 = gate_cfg_pkg::state_primary_side_config;
  localparam gate_cfg_pkg::dev_state_e S2 = gate_cfg_pkg::state_cfg2;
  localparam gate_cfg_pkg::dev_state_e SA = gate_cfg_pkg::state_active;
  localparam logic [3:0] CA = 4'h0;
  typedef struct {gate_cfg_pkg::dev_state_e st; logic [4:0] ra; logic [15:0] wd; logic [15:0] ex;} row_s;
  row_s rows [23] = '{'{S2, 5'h13, 16'h1234, 16'h1234}, '{SA, 5'h13, 16'h5555, 16'h1234},
    '{SA, 5'h14, 16'hA5C3, 16'hA5C3}, '{S1, 5'h14, 16'h0000, 16'hA5C3}, '{S2, 5'h1B, 16'h1111, 16'h1111},
    '{SA, 5'h1C, 16'h2222, 16'h2222}, '{SA, 5'h1D, 16'h3333, 16'h0000}, '{S2, 5'h1D, 16'h3333, 16'h3333},
    '{S2, 5'h1E, 16'h4444, 16'h4444}, '{SA, 5'h1E, 16'h0000, 16'h4444}, '{S2, 5'h15, 16'h0007, 16'h0000},
    '{S1, 5'h15, 16'h00F0, 16'h00F0}, '{S2, 5'h0D, 16'hFFFF, 16'hA005}, '{S1, 5'h0E, 16'hFFFF, 16'hA002},
    '{SA, 5'h0F, 16'hFFFF, 16'hA004}, '{S2, 5'h10, 16'hFFFF, 16'hA006}, '{S2, 5'h11, 16'hFFFF, 16'hA011},
    '{S2, 5'h12, 16'hFFFF, 16'hA012}, '{S2, 5'h16, 16'hFFFF, 16'hF001}, '{SA, 5'h17, 16'hFFFF, 16'hF002},
    '{S1, 5'h18, 16'hFFFF, 16'hF003}, '{S2, 5'h19, 16'hFFFF, 16'hF004}, '{S2, 5'h1A, 16'hFFFF, 16'hF005}};
  int codes [3] = '{0, 1, 63};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, mosi, fault_event, temp_warn, seen;
  logic [1:0] pwm_in, pwm_filtered;
  gate_cfg_pkg::dev_state_e st = S2;
  gate_cfg_pkg::adc_results_s adc_in = '{16'hA005, 16'hA002, 16'hA004, 16'hA006, 16'hA011, 16'hA012};
  gate_cfg_pkg::fault_flags_s faults_in = '{16'hF001, 16'hF002, 16'hF003, 16'hF004, 16'hF005};
  logic alarm_n, warn_n, warn_oe;
  // released pin shows the inverse, so a stale bit cannot pass as data
  wire logic miso_line;
  assign miso_line = warn_oe ? warn_n : ~warn_n;
  logic [6:0] dead;
  logic [15:0] primary, diag_one, diag_two, conv, pin_cfg, got;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  spi_host_model host (.clk(clk), .miso(miso_line), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  gate_driver_config_register_bank dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .dev_state(st), .adc_in(adc_in), .faults_in(faults_in), .fault_event(fault_event),
    .primary_temp_warn(temp_warn), .pwm_input_positive(pwm_in[0]), .pwm_input_negative(pwm_in[1]),
    .fault_alarm_out_n(alarm_n), .warning_out_n(warn_n), .warning_out_oe(warn_oe), .pwm_filtered(pwm_filtered),
    .dead_time_cycles(dead), .primary_side_config(primary), .diag_command_one(diag_one),
    .diag_command_two(diag_two), .converter_settings(conv), .serial_out_pin_settings(pin_cfg));
  // ************************************************************
  // bus and run helpers
  // ************************************************************
  task automatic cmd(input logic [3:0] op, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({CA, op, d}, r);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    cmd(gate_cfg_pkg::OP_WR_RA, {3'h0, ra});
    cmd(gate_cfg_pkg::OP_WRH, v[15:8]);
    cmd(gate_cfg_pkg::OP_WRL, v[7:0]);
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] v);
    cmd(gate_cfg_pkg::OP_RD, {3'h0, ra});
    host.xfer({CA, gate_cfg_pkg::OP_RD, 3'h0, ra}, v); // word arrives in the following frame
  endtask
  task automatic pulse(input int idx, input int len, output logic hit);
    hit = 1'b0;
    pwm_in[idx] <= 1'b1;
    for (int k = 0; k < len + 16; k++) begin
      @(posedge clk);
      if (k == len - 1) pwm_in[idx] <= 1'b0;
      #1 if (pwm_filtered[idx] === 1'b1) hit = 1'b1;
    end
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // run of about 40k clocks expected; the ceiling leaves room
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      complete_run();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    fault_event <= 1'b0;
    temp_warn <= 1'b0;
    pwm_in <= 2'b00;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 `CHECK(primary, gate_cfg_pkg::PRIMARY_RESET)
    `CHECK(dead, 7'h00)
    `CHECK(alarm_n, 1'b1)
    `CHECK(conv, 16'h0000)
    $display("reset test done");
    @(posedge clk);
    wr(5'h00, 16'h0C40);
    `CHECK(primary, 16'h0C40)
    foreach (rows[i]) begin
      st <= rows[i].st;
      wr(rows[i].ra, rows[i].wd);
      rd(rows[i].ra, got);
      `CHECK(got, rows[i].ex)
    end
    $display("table test done");
    st <= S2;
    wr(5'h1F, 16'hFFFF);
    `CHECK({primary, diag_one, diag_two}, {16'h0C40, 16'h1111, 16'h2222})
    `CHECK({conv, pin_cfg}, {16'h3333, 16'h4444})
    $display("unlisted offset test done");
    wr(5'h00, 16'hE3C0);
    `CHECK(primary, 16'hE3C0)
    rd(5'h00, got);
    `CHECK(got, 16'hE3C0)
    foreach (codes[i]) begin
      cmd(gate_cfg_pkg::OP_WRL, {2'b01, 6'(codes[i])});
      got = 16'((codes[i] * gate_cfg_pkg::DEAD_STEP_NS + gate_cfg_pkg::DEAD_BASE_NS + 49) / 50);
      if (codes[i] == 0) got = 16'h0000;
      `CHECK(dead, got[6:0])
    end
    $display("dead time test done");
    pulse(0, 2, seen); // a one-clock blip never clears the pin synchroniser
    `CHECK(seen, 1'b1)
    cmd(gate_cfg_pkg::OP_WRH, 8'hFB);
    pulse(1, 4, seen);
    `CHECK(seen, 1'b0)
    pulse(1, 8, seen);
    `CHECK(seen, 1'b1)
    $display("deglitch test done");
    temp_warn <= 1'b1;
    repeat (8) @(posedge clk);
    `CHECK({alarm_n, warn_oe}, 2'b00)
    cmd(gate_cfg_pkg::OP_WRL, 8'h00);
    `CHECK({alarm_n, warn_n, warn_oe}, 3'b101)
    cmd(gate_cfg_pkg::OP_WRH, 8'hFF);
    `CHECK(warn_n, 1'b1)
    temp_warn <= 1'b0;
    fault_event <= 1'b1;
    repeat (8) @(posedge clk);
    `CHECK(alarm_n, 1'b0)
    fault_event <= 1'b0;
    $display("warning pin test done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHECK({primary, diag_one, conv}, {gate_cfg_pkg::PRIMARY_RESET, 32'h0000_0000})
    `CHECK({alarm_n, warn_n, warn_oe, pwm_filtered, dead}, {3'b111, 2'b00, 7'h00})
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHECK(primary, gate_cfg_pkg::PRIMARY_RESET)
    $display("mid-run reset test done");
    complete_run();
  end
endmodule // gate_driver_config_register_bank_bench
`default_nettype wire
